// ==== hw/cpsi_sysif.sv ====
// pin level control: bus ownership handshake, straps, resets, interrupts, trace, float
//
// Design decisions made here: the register addresses and strobed register access.
`include "cpsi_map.svh"

module cpsi_sysif #(
    parameter int NUM_INT = `CPSI_NUM_INT
) (
    input  wire logic                    sys_clk,
    input  wire logic                    reset_n,
    input  wire logic                    warm_reset_n,
    input  wire logic                    clk_en,
    input  wire logic [`CPSI_ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]             reg_wr_data,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [31:0]             reg_rd_data,
    input  wire logic                    legacy_protocol_select,
    input  wire logic [1:0]              clock_ratio_select,
    input  wire logic                    byte_order_select,
    input  wire logic                    agent_bus_request,
    input  wire logic                    write_accept_ready,
    input  wire logic                    agent_ok_in,
    input  wire logic                    read_accept_ready,
    input  wire logic [NUM_INT-1:0]      int_req,
    input  wire logic                    nmi_req,
    input  wire logic                    float_outputs,
    input  wire logic                    break_trigger_io_i,
    output logic                         break_trigger_io_o,
    output logic                         break_trigger_io_oe_n,
    output logic                         release_owns_out,
    output logic                         proc_request_out,
    output logic      [3:0]              trace_nibble_out,
    output logic                         trace_packet_last,
    output logic                         trace_clock_out,
    output logic                         outputs_oe_n,
    output logic                         core_int_req,
    output logic                         core_nmi_req,
    output logic      [3:0]              core_ratio_x2,
    output logic                         byte_order_big
);

    // the state struct holds exactly the documented interrupt count
    initial begin
        if (NUM_INT != `CPSI_NUM_INT) begin
            $error("cpsi_sysif: interrupt count must match the cause field");
        end
    end

    cpsi_pkg::cpsi_state_s q_r;
    cpsi_pkg::cpsi_state_s q_nxt;

    logic       wr_cause;
    logic       wr_mask;
    logic       wr_ctrl;
    logic       wr_trace;
    logic       trc_busy;
    logic [3:0] trc_nib;
    logic       trc_last;
    logic       served;
    logic       accept;
    logic       sw_go;
    logic [3:0] x2_dec;

    // register write decode
    assign wr_cause = reg_wr && (reg_addr == `CPSI_OFS_CAUSE);
    assign wr_mask  = reg_wr && (reg_addr == `CPSI_OFS_MASK);
    assign wr_ctrl  = reg_wr && (reg_addr == `CPSI_OFS_CTRL);
    assign wr_trace = reg_wr && (reg_addr == `CPSI_OFS_TRACE);
    assign sw_go    = wr_ctrl && reg_wr_data[`CPSI_CTRL_GO];

    // acceptance of the outstanding request depends on the protocol
    always_comb begin
        if (q_r.legacy) begin
            accept = agent_ok_in;
        end else if (q_r.is_wr) begin
            accept = write_accept_ready;
        end else begin
            accept = read_accept_ready;
        end
    end
    assign served = q_r.pend && (q_r.bus == cpsi_pkg::bus_master) && accept;

    // ratio code to core/system ratio in half steps
    always_comb begin
        case (q_r.ratio)
            `CPSI_RATIO_4_1: x2_dec = `CPSI_X2_4_1;
            `CPSI_RATIO_3_1: x2_dec = `CPSI_X2_3_1;
            `CPSI_RATIO_5_2: x2_dec = `CPSI_X2_5_2;
            `CPSI_RATIO_2_1: x2_dec = `CPSI_X2_2_1;
            default:         x2_dec = `CPSI_X2_2_1;
        endcase
    end

    // next state of the whole block
    always_comb begin
        q_nxt         = q_r;
        q_nxt.rd_data = `CPSI_RST_WORD;

        // interrupt levels follow the pins every cycle
        q_nxt.int_lvl  = int_req;
        q_nxt.nmi_prev = nmi_req;
        q_nxt.brk_in   = break_trigger_io_i;

        // nmi edge is sticky; a new edge wins over a software clear
        if (wr_cause && reg_wr_data[`CPSI_CAUSE_NMI]) begin
            q_nxt.nmi_pend = 1'b0;
        end
        if (nmi_req && !q_r.nmi_prev) begin
            q_nxt.nmi_pend = 1'b1;
        end

        if (wr_mask) begin
            q_nxt.mask = reg_wr_data[NUM_INT-1:0];
            q_nxt.gie  = reg_wr_data[`CPSI_MASK_GIE];
        end

        // request bookkeeping; a new request wins over completion
        if (served) begin
            q_nxt.pend = 1'b0;
        end
        if (wr_ctrl) begin
            q_nxt.brk_drv = reg_wr_data[`CPSI_CTRL_BRK_DRV];
            q_nxt.brk_val = reg_wr_data[`CPSI_CTRL_BRK_VAL];
        end
        if (sw_go && (!q_r.pend || served)) begin
            q_nxt.pend  = 1'b1;
            q_nxt.is_wr = reg_wr_data[`CPSI_CTRL_WR];
        end

        // ownership handshake with the external agent
        case (q_r.bus)
            cpsi_pkg::bus_master: begin
                if (agent_bus_request) begin
                    q_nxt.bus = cpsi_pkg::bus_slave;
                end
            end
            cpsi_pkg::bus_slave: begin
                if (!agent_bus_request) begin
                    q_nxt.bus = cpsi_pkg::bus_master;
                end
            end
            default: begin
                q_nxt.bus = cpsi_pkg::bus_master;
            end
        endcase

        // shared release / ownership pin
        if (q_r.legacy) begin
            q_nxt.rel_owns = (q_nxt.bus == cpsi_pkg::bus_master);
        end else begin
            q_nxt.rel_owns = (q_r.bus == cpsi_pkg::bus_master)
                             && (q_nxt.bus == cpsi_pkg::bus_slave);
        end

        // request pin: pending in native, bus wanted in legacy
        if (q_r.legacy) begin
            q_nxt.req_out = q_nxt.pend && (q_nxt.bus != cpsi_pkg::bus_master);
        end else begin
            q_nxt.req_out = q_nxt.pend;
        end

        // interrupt lines to the core; nmi bypasses every mask
        q_nxt.int_out = q_r.gie && |(q_r.int_lvl & q_r.mask);
        q_nxt.nmi_out = q_r.nmi_pend;

        // pin drivers float on request
        q_nxt.oe_n     = float_outputs;
        q_nxt.brk_oe_n = float_outputs || !q_r.brk_drv;
        q_nxt.ratio_x2 = x2_dec;

        // register read data, one cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                `CPSI_OFS_CAUSE: begin
                    q_nxt.rd_data[`CPSI_CAUSE_INT_HI:`CPSI_CAUSE_INT_LO] = q_r.int_lvl;
                    q_nxt.rd_data[`CPSI_CAUSE_NMI] = q_r.nmi_pend;
                end
                `CPSI_OFS_MASK: begin
                    q_nxt.rd_data[NUM_INT-1:0]    = q_r.mask;
                    q_nxt.rd_data[`CPSI_MASK_GIE] = q_r.gie;
                end
                `CPSI_OFS_CTRL: begin
                    q_nxt.rd_data[`CPSI_CTRL_GO]      = q_r.pend;
                    q_nxt.rd_data[`CPSI_CTRL_WR]      = q_r.is_wr;
                    q_nxt.rd_data[`CPSI_CTRL_OWNS]    = (q_r.bus == cpsi_pkg::bus_master);
                    q_nxt.rd_data[`CPSI_CTRL_TBUSY]   = trc_busy;
                    q_nxt.rd_data[`CPSI_CTRL_BRK_DRV] = q_r.brk_drv;
                    q_nxt.rd_data[`CPSI_CTRL_BRK_VAL] = q_r.brk_val;
                    q_nxt.rd_data[`CPSI_CTRL_BRK_IN]  = q_r.brk_in;
                end
                `CPSI_OFS_STRAP: begin
                    q_nxt.rd_data[`CPSI_STRAP_LEGACY] = q_r.legacy;
                    q_nxt.rd_data[`CPSI_STRAP_RATIO_HI:`CPSI_STRAP_RATIO_LO] = q_r.ratio;
                    q_nxt.rd_data[`CPSI_STRAP_BIG]    = q_r.big;
                    q_nxt.rd_data[`CPSI_STRAP_DBG]    = q_r.dbg_boot;
                    q_nxt.rd_data[`CPSI_STRAP_X2_HI:`CPSI_STRAP_X2_LO] = q_r.ratio_x2;
                end
                default: begin
                    q_nxt.rd_data = `CPSI_RST_WORD;
                end
            endcase
        end

        // warm reset clears logical state and keeps the straps
        if (!warm_reset_n) begin
            q_nxt.bus      = cpsi_pkg::bus_master;
            q_nxt.pend     = 1'b0;
            q_nxt.is_wr    = 1'b0;
            q_nxt.nmi_pend = 1'b0;
            q_nxt.mask     = `CPSI_RST_MASK;
            q_nxt.gie      = 1'b0;
            q_nxt.brk_drv  = 1'b0;
            q_nxt.brk_val  = 1'b0;
            q_nxt.rel_owns = 1'b0;
            q_nxt.req_out  = 1'b0;
            q_nxt.int_out  = 1'b0;
            q_nxt.nmi_out  = 1'b0;
            q_nxt.brk_oe_n = 1'b1;
        end
    end

    // full reset clears the state, floats the output enables, sets the ratio to 2:1 and catches the straps while held
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            q_r          <= '0;
            q_r.bus      <= cpsi_pkg::bus_master;
            q_r.legacy   <= legacy_protocol_select;
            q_r.ratio    <= clock_ratio_select;
            q_r.big      <= byte_order_select;
            q_r.dbg_boot <= break_trigger_io_i;
            q_r.ratio_x2 <= `CPSI_RST_X2;
            q_r.oe_n     <= 1'b1;
            q_r.brk_oe_n <= 1'b1;
        end else if (clk_en) begin
            q_r <= q_nxt;
        end
    end

    // trace packets are loaded from the trace register
    cpsi_trace_ser #(
        .NIBBLES   (`CPSI_TRC_NIBBLES)
    ) u_trace (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .clk_en    (clk_en),
        .flush     (!warm_reset_n),
        .load      (wr_trace),
        .load_data (reg_wr_data[`CPSI_TRC_NIBBLES*4-1:0]),
        .busy      (trc_busy),
        .nibble    (trc_nib),
        .last      (trc_last)
    );

    // pin and core outputs
    assign reg_rd_data           = q_r.rd_data;
    assign release_owns_out      = q_r.rel_owns;
    assign proc_request_out      = q_r.req_out;
    assign break_trigger_io_o    = q_r.brk_val;
    assign break_trigger_io_oe_n = q_r.brk_oe_n;
    assign outputs_oe_n          = q_r.oe_n;
    assign core_int_req          = q_r.int_out;
    assign core_nmi_req          = q_r.nmi_out;
    assign core_ratio_x2         = q_r.ratio_x2;
    assign byte_order_big        = q_r.big;
    assign trace_nibble_out      = trc_nib;
    assign trace_packet_last     = trc_last;
    assign trace_clock_out       = sys_clk;

endmodule : cpsi_sysif

// ==== hw/cpsi_map.svh ====
// register offsets, field positions, reset values and codes of the pin control block
`ifndef CPSI_MAP_SVH
`define CPSI_MAP_SVH

// register byte addresses
`define CPSI_ADDR_W          8
`define CPSI_OFS_CAUSE       8'h00
`define CPSI_OFS_MASK        8'h04
`define CPSI_OFS_CTRL        8'h08
`define CPSI_OFS_STRAP       8'h0c
`define CPSI_OFS_TRACE       8'h10

// cause register fields
`define CPSI_NUM_INT         5
`define CPSI_CAUSE_INT_LO    10
`define CPSI_CAUSE_INT_HI    14
`define CPSI_CAUSE_NMI       15

// mask register fields
`define CPSI_MASK_GIE        5

// control register fields
`define CPSI_CTRL_GO         0
`define CPSI_CTRL_WR         1
`define CPSI_CTRL_OWNS       2
`define CPSI_CTRL_TBUSY      3
`define CPSI_CTRL_BRK_DRV    4
`define CPSI_CTRL_BRK_VAL    5
`define CPSI_CTRL_BRK_IN     6

// strap register fields
`define CPSI_STRAP_LEGACY    0
`define CPSI_STRAP_RATIO_LO  1
`define CPSI_STRAP_RATIO_HI  2
`define CPSI_STRAP_BIG       3
`define CPSI_STRAP_DBG       4
`define CPSI_STRAP_X2_LO     8
`define CPSI_STRAP_X2_HI     11

// clock ratio codes and the core/system ratio in half steps
`define CPSI_RATIO_4_1       2'h3
`define CPSI_RATIO_3_1       2'h2
`define CPSI_RATIO_5_2       2'h1
`define CPSI_RATIO_2_1       2'h0
`define CPSI_X2_4_1          4'h8
`define CPSI_X2_3_1          4'h6
`define CPSI_X2_5_2          4'h5
`define CPSI_X2_2_1          4'h4

// trace packet shape
`define CPSI_TRC_NIBBLES     4
`define CPSI_TRC_CNT_W       3

// reset values
`define CPSI_RST_MASK        5'h00
`define CPSI_RST_WORD        32'h0000_0000
`define CPSI_RST_X2          4'h4

`endif

// ==== hw/cpsi_pkg.sv ====
// types shared by the pin control block and its trace serialiser
`include "cpsi_map.svh"
package cpsi_pkg;

    typedef enum logic {
        bus_master,
        bus_slave
    } cpsi_bus_e;

    typedef struct packed {
        cpsi_bus_e                  bus;
        logic                       legacy;
        logic [1:0]                 ratio;
        logic                       big;
        logic                       dbg_boot;
        logic [`CPSI_NUM_INT-1:0]   int_lvl;
        logic                       nmi_prev;
        logic                       nmi_pend;
        logic [`CPSI_NUM_INT-1:0]   mask;
        logic                       gie;
        logic                       pend;
        logic                       is_wr;
        logic                       brk_drv;
        logic                       brk_val;
        logic                       brk_in;
        logic                       rel_owns;
        logic                       req_out;
        logic                       oe_n;
        logic                       brk_oe_n;
        logic                       int_out;
        logic                       nmi_out;
        logic [3:0]                 ratio_x2;
        logic [31:0]                rd_data;
    } cpsi_state_s;

    typedef struct packed {
        logic [`CPSI_TRC_NIBBLES*4-1:0] shreg;
        logic [`CPSI_TRC_CNT_W-1:0]     cnt;
        logic                           busy;
        logic [3:0]                     nib;
        logic                           last;
    } cpsi_trace_s;

endpackage : cpsi_pkg

// ==== hw/cpsi_trace_ser.sv ====
// trace serialiser: sends one packet as nibbles and marks the final one
`include "cpsi_map.svh"
module cpsi_trace_ser #(
    parameter int NIBBLES = `CPSI_TRC_NIBBLES
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    input  wire logic                 flush,
    input  wire logic                 load,
    input  wire logic [NIBBLES*4-1:0] load_data,
    output logic                      busy,
    output logic [3:0]                nibble,
    output logic                      last
);

    // the struct is sized by the header, so the parameter must agree
    initial begin
        if (NIBBLES != `CPSI_TRC_NIBBLES || NIBBLES >= (1 << `CPSI_TRC_CNT_W)) begin
            $error("cpsi_trace_ser: unsupported packet length");
        end
    end

    cpsi_pkg::cpsi_trace_s q_r;
    cpsi_pkg::cpsi_trace_s q_nxt;

    // shift out low nibble first; a load while busy is ignored
    always_comb begin
        q_nxt = q_r;
        if (flush) begin
            q_nxt = '0;
        end else if (q_r.busy) begin
            q_nxt.nib   = q_r.shreg[3:0];
            q_nxt.shreg = q_r.shreg >> 4;
            q_nxt.last  = (q_r.cnt == `CPSI_TRC_CNT_W'(1));
            q_nxt.busy  = (q_r.cnt != `CPSI_TRC_CNT_W'(1));
            q_nxt.cnt   = q_r.cnt - `CPSI_TRC_CNT_W'(1);
        end else begin
            q_nxt.nib  = 4'h0;
            q_nxt.last = 1'b0;
            if (load) begin
                q_nxt.shreg = load_data;
                q_nxt.cnt   = `CPSI_TRC_CNT_W'(NIBBLES);
                q_nxt.busy  = 1'b1;
            end
        end
    end

    // state register, frozen while the clock enable is low
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            q_r <= '0;
        end else if (clk_en) begin
            q_r <= q_nxt;
        end
    end

    assign busy   = q_r.busy;
    assign nibble = q_r.nib;
    assign last   = q_r.last;

endmodule : cpsi_trace_ser

// ==== tb/cpsi_agent_model.sv ====
// external agent model: bus request on demand and periodic accept strobes
module cpsi_agent_model (
    input  wire logic       sys_clk,
    input  wire logic       want_bus,
    input  wire logic [3:0] delay,
    output logic            agent_bus_request,
    output logic            write_accept_ready,
    output logic            read_accept_ready,
    output logic            agent_ok_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_cnt = 4'h0;
    logic       open;

    initial {agent_bus_request, write_accept_ready, read_accept_ready, agent_ok_in} = 4'h0;

    // a slow agent (large delay) accepts rarely, a fast one (delay 0) every cycle
    assign open = (wait_cnt >= delay);
    always @(posedge sys_clk) begin
        agent_bus_request  <= want_bus;
        wait_cnt           <= open ? 4'h0 : wait_cnt + 4'h1;
        write_accept_ready <= open;
        read_accept_ready  <= open;
        agent_ok_in        <= open;
    end
endmodule : cpsi_agent_model

// ==== tb/cpsi_sysif_sva.sv ====
// port level assertions for the pin control block
module cpsi_sysif_sva #(
    parameter int NUM_INT = 5
) (
    input wire logic               sys_clk,
    input wire logic               reset_n,
    input wire logic               warm_reset_n,
    input wire logic               clk_en,
    input wire logic               reg_wr,
    input wire logic [NUM_INT-1:0] int_req,
    input wire logic               nmi_req,
    input wire logic               float_outputs,
    input wire logic               legacy_protocol_select,
    input wire logic [1:0]         clock_ratio_select,
    input wire logic               byte_order_select,
    input wire logic               agent_bus_request,
    input wire logic               release_owns_out,
    input wire logic               trace_clock_out,
    input wire logic               outputs_oe_n,
    input wire logic               core_int_req,
    input wire logic               core_nmi_req,
    input wire logic [3:0]         core_ratio_x2,
    input wire logic               byte_order_big
);
    logic       leg_q;
    logic [1:0] ratio_q;
    logic       big_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // straps as the device should have caught them in full reset
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            leg_q   <= legacy_protocol_select;
            ratio_q <= clock_ratio_select;
            big_q   <= byte_order_select;
        end
    end

    a_float_all_oe: assert property (clk_en |=> outputs_oe_n == $past(float_outputs))
        else $error("output enable does not follow float input");
    a_trace_clk_copy: assert property (@(sys_clk) disable iff (!reset_n)
        trace_clock_out == sys_clk) else $error("trace clock differs from system clock");
    a_nmi_never_masked: assert property ($rose(nmi_req) && clk_en && warm_reset_n ##1
        clk_en && warm_reset_n && !reg_wr |=> core_nmi_req)
        else $error("nmi edge did not reach core");
    a_int_quiet_low: assert property (clk_en && int_req == '0 ##1 clk_en |=> !core_int_req)
        else $error("core interrupt without any request level");
    a_strap_ratio_held: assert property (clk_en |=> core_ratio_x2 == 4'h4 + ratio_q
        + (ratio_q == 2'h3) && byte_order_big == big_q)
        else $error("ratio or byte order differs from captured straps");
    a_native_rel_pulse: assert property (!leg_q && clk_en && release_owns_out
        |=> !release_owns_out) else $error("native release longer than one cycle");
    a_native_rel_grant: assert property (!leg_q && clk_en && !agent_bus_request ##1
        clk_en && warm_reset_n && agent_bus_request |=> release_owns_out)
        else $error("native release missing after agent request");
    a_legacy_owns_hi: assert property (leg_q && clk_en && !agent_bus_request ##1
        clk_en && warm_reset_n && !agent_bus_request |=> release_owns_out)
        else $error("legacy owner flag low while processor owns bus");
    a_legacy_owns_lo: assert property (leg_q && clk_en && agent_bus_request ##1
        clk_en && warm_reset_n && agent_bus_request |=> !release_owns_out)
        else $error("legacy owner flag high after bus handed over");
endmodule : cpsi_sysif_sva

bind cpsi_sysif cpsi_sysif_sva #(.NUM_INT(NUM_INT)) cpsi_sysif_sva_i (.sys_clk, .reset_n,
    .warm_reset_n, .clk_en, .reg_wr, .int_req, .nmi_req, .float_outputs,
    .legacy_protocol_select, .clock_ratio_select, .byte_order_select, .agent_bus_request,
    .release_owns_out, .trace_clock_out, .outputs_oe_n, .core_int_req, .core_nmi_req,
    .core_ratio_x2, .byte_order_big);

// ==== tb/cpsi_sysif_tb.sv ====
// self-checking testbench for the pin control block
`include "cpsi_map.svh"
module cpsi_sysif_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk = 1'b0, reset_n = 1'b0, warm_reset_n = 1'b1, clk_en = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wr_data = 32'h0, reg_rd_data;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, nmi_req = 1'b0, float_outputs = 1'b0;
    logic        legacy_protocol_select = 1'b0, byte_order_select = 1'b0, dbg_drv = 1'b0;
    logic [1:0]  clock_ratio_select = 2'h0;
    logic [4:0]  int_req = 5'h00;
    logic        want_bus = 1'b0, agent_bus_request, write_accept_ready;
    logic        agent_ok_in, read_accept_ready, break_trigger_io_i, break_trigger_io_o;
    logic        break_trigger_io_oe_n, release_owns_out, proc_request_out;
    logic        trace_packet_last, trace_clock_out, outputs_oe_n, core_int_req;
    logic        core_nmi_req, byte_order_big;
    logic [3:0]  delay = 4'h3, trace_nibble_out, core_ratio_x2;
    int          fails = 0, checked = 0;

    always #50 sys_clk = ~sys_clk;

    // debug pin level: the device when it drives, else the external debug logic
    assign break_trigger_io_i = break_trigger_io_oe_n ? dbg_drv : break_trigger_io_o;

    cpsi_agent_model cpsi_agent_model_i (.sys_clk, .want_bus, .delay, .agent_bus_request,
        .write_accept_ready, .read_accept_ready, .agent_ok_in);

    cpsi_sysif cpsi_sysif_i (.sys_clk, .reset_n, .warm_reset_n, .clk_en, .reg_addr,
        .reg_wr_data, .reg_wr, .reg_rd, .reg_rd_data, .legacy_protocol_select,
        .clock_ratio_select, .byte_order_select, .agent_bus_request, .write_accept_ready,
        .agent_ok_in, .read_accept_ready, .int_req, .nmi_req, .float_outputs,
        .break_trigger_io_i, .break_trigger_io_o, .break_trigger_io_oe_n, .release_owns_out,
        .proc_request_out, .trace_nibble_out, .trace_packet_last, .trace_clock_out,
        .outputs_oe_n, .core_int_req, .core_nmi_req, .core_ratio_x2, .byte_order_big);

    task automatic final_report();
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr      <= 1'b1;
        reg_addr    <= a;
        reg_wr_data <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rd_data, e);
    endtask : rd

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // full reset with the given straps, held four cycles
    task automatic cold(input logic leg, input logic [1:0] r, input logic big, input logic dbg);
        @(posedge sys_clk);
        reset_n                <= 1'b0;
        legacy_protocol_select <= leg;
        clock_ratio_select     <= r;
        byte_order_select      <= big;
        dbg_drv                <= dbg;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
    endtask : cold

    task automatic wait_req_low();
        int i;
        #1;
        for (i = 0; i < 40 && proc_request_out !== 1'b0; i++) tick(1);
        if (i == 40) begin
            fails++;
            final_report();
        end
    endtask : wait_req_low

    // every ratio code; straps changed in run must be ignored
    task automatic t_straps();
        logic [1:0]  r;
        logic [31:0] e;
        for (int k = 0; k < 4; k++) begin
            r = k[1:0];
            e = {20'h0, 4'h4 + r + (r == 2'h3), 3'h0, r[0] ^ r[1], r[1], r, r[0]};
            cold(r[0], r, r[1], r[0] ^ r[1]);
            rd(`CPSI_OFS_STRAP, e);
            chk({28'h0, core_ratio_x2}, {28'h0, e[11:8]});
            legacy_protocol_select <= ~r[0];
            clock_ratio_select     <= ~r;
            byte_order_select      <= ~r[1];
            dbg_drv                <= 1'b0;
            rd(`CPSI_OFS_STRAP, e);
        end
    endtask : t_straps

    // legacy: request asks for the bus, owner flag once granted
    task automatic t_legacy();
        want_bus <= 1'b1;
        tick(3);
        chk(release_owns_out, 1'b0);
        wr(`CPSI_OFS_CTRL, 32'h1);
        tick(2);
        chk(proc_request_out, 1'b1);
        want_bus <= 1'b0;
        wait_req_low();
        chk(release_owns_out, 1'b1);
        tick(4);
        rd(`CPSI_OFS_CTRL, 32'h4);
    endtask : t_legacy

    // native: refused while slave, served once the agent lets go
    task automatic t_native();
        want_bus <= 1'b1;
        wr(`CPSI_OFS_CTRL, 32'h3);
        tick(6);
        chk(proc_request_out, 1'b1);
        rd(`CPSI_OFS_CTRL, 32'h3);
        want_bus <= 1'b0;
        wait_req_low();
        delay <= 4'h0;
        wr(`CPSI_OFS_CTRL, 32'h1);
        wait_req_low();
        rd(`CPSI_OFS_CTRL, 32'h4);
    endtask : t_native

    task automatic t_irq();
        int_req <= 5'h15;
        rd(`CPSI_OFS_CAUSE, 32'h5400);
        chk(core_int_req, 1'b0);
        wr(`CPSI_OFS_MASK, 32'h24);
        tick(1);
        chk(core_int_req, 1'b1);
        wr(`CPSI_OFS_MASK, 32'h22);
        tick(1);
        chk(core_int_req, 1'b0);
        nmi_req <= 1'b1;
        tick(2);
        chk(core_nmi_req, 1'b1);
        rd(`CPSI_OFS_CAUSE, 32'hd400);
        wr(`CPSI_OFS_CAUSE, 32'h8000);
        int_req <= 5'h00;
        nmi_req <= 1'b0;
        rd(`CPSI_OFS_CAUSE, 32'h0);
    endtask : t_irq

    // one packet, a second load while busy is dropped
    task automatic t_trace();
        logic [15:0] sh;
        int          i;
        int          n;
        @(posedge sys_clk);
        reg_wr      <= 1'b1;
        reg_addr    <= `CPSI_OFS_TRACE;
        reg_wr_data <= 32'hc3a5;
        @(posedge sys_clk);
        reg_wr_data <= 32'h0f0f;    // back to back: this load meets a busy serialiser
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        for (i = 0; i < 8; i++) begin
            #1 sh = {trace_nibble_out, sh[15:4]};
            if (trace_packet_last === 1'b1) break;
            @(posedge sys_clk);
        end
        chk({16'h0, sh}, 32'hc3a5);
        n = 0;
        for (i = 0; i < 8; i++) begin
            tick(1);
            n += (trace_packet_last !== 1'b0);
        end
        chk(n, 0);
    endtask : t_trace

    task automatic t_float();
        wr(`CPSI_OFS_CTRL, 32'h30);
        tick(1);
        chk({break_trigger_io_oe_n, break_trigger_io_o}, 2'b01);
        rd(`CPSI_OFS_CTRL, 32'h74);
        float_outputs <= 1'b1;
        tick(2);
        chk({outputs_oe_n, break_trigger_io_oe_n}, 2'b11);
        float_outputs <= 1'b0;
        tick(2);
        chk(outputs_oe_n, 1'b0);
    endtask : t_float

    // warm reset clears logic state but keeps straps
    task automatic t_warm();
        wr(`CPSI_OFS_MASK, 32'h3f);
        warm_reset_n <= 1'b0;
        @(posedge sys_clk);
        warm_reset_n <= 1'b1;
        rd(`CPSI_OFS_MASK, 32'h0);
        chk(break_trigger_io_oe_n, 1'b1);
        rd(`CPSI_OFS_STRAP, 32'h400);
        rd(8'h20, 32'h0);
    endtask : t_warm

    initial begin
        t_straps();
        t_legacy();
        cold(1'b0, 2'h0, 1'b0, 1'b0);
        t_native();
        t_irq();
        t_trace();
        t_float();
        t_warm();
        final_report();
    end
endmodule : cpsi_sysif_tb
